// ---- lcc_regs.vh ----
`ifndef LCC_REGS_VH
`define LCC_REGS_VH
// ****************************************************************
// register subaddresses
// ****************************************************************
`define LCC_ADDR_LEVEL_COEF   8'h28
`define LCC_ADDR_FINE_CLAMP   8'h2a
`define LCC_ADDR_POWER_DOWN   8'h2b
`define LCC_ADDR_CONV_SETUP   8'h2c
`define LCC_ADDR_COARSE_CLAMP 8'h2d
`define LCC_ADDR_GREEN_CLAMP  8'h2e
`define LCC_ADDR_PLACEMENT    8'h31
`define LCC_ADDR_LEVEL_EN     8'h26
// ****************************************************************
// reset values
// ****************************************************************
`define LCC_RST_BYTE          8'h00
// ****************************************************************
// field positions and writable masks
// ****************************************************************
`define LCC_VERT_COEF_MSB     6
`define LCC_VERT_COEF_LSB     3
`define LCC_HORZ_COEF_MSB     2
`define LCC_HORZ_COEF_LSB     0
`define LCC_MASK_LEVEL_COEF   8'h7f
`define LCC_MASK_FINE_CLAMP   8'h1f
`define LCC_MASK_POWER_DOWN   8'h7f
`define LCC_MASK_CONV_SETUP   8'hff
`define LCC_MASK_COARSE_CLAMP 8'hc7
`define LCC_MASK_GREEN_CLAMP  8'h80
`define LCC_MASK_PLACEMENT    8'hff
`define LCC_MASK_LEVEL_EN     8'h80
`define LCC_LEVEL_EN_BIT      7
// ****************************************************************
// averaging sizes
// ****************************************************************
`define LCC_MIN_SAMPLES_LOG2  3
`endif

// ---- lcc_level_control.v ----
`timescale 1ns/10ps
`include "lcc_regs.vh"
module lcc_level_control
(
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire        hsync_start,
  input  wire [9:0]  blank_sample,
  output reg  [15:0] level_offset,
  output reg         offset_update,
  output wire        level_loop_en,
  output wire [2:0]  fine_clamp_en,
  output wire [1:0]  fine_clamp_speed,
  output wire [2:0]  coarse_clamp_en,
  output wire [1:0]  coarse_clamp_current,
  output wire        green_sync_clamp_en,
  output wire        sync_on_green_pd,
  output wire        slicer_pd,
  output wire        reference_pd,
  output wire        current_control_pd,
  output wire        blue_converter_pd,
  output wire        green_converter_pd,
  output wire        red_converter_pd,
  output wire [7:0]  converter_setup
);
  // ****************************************************************
  // register file
  // ****************************************************************
  reg  [7:0]  level_coef_reg;
  reg  [7:0]  fine_clamp_reg;
  reg  [7:0]  power_down_reg;
  reg  [7:0]  conv_setup_reg;
  reg  [7:0]  coarse_clamp_reg;
  reg  [7:0]  green_clamp_reg;
  reg  [7:0]  placement_reg;
  reg  [7:0]  level_en_reg;

  // writes keep only the defined bits
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      level_coef_reg   <= `LCC_RST_BYTE;
      fine_clamp_reg   <= `LCC_RST_BYTE;
      power_down_reg   <= `LCC_RST_BYTE;
      conv_setup_reg   <= `LCC_RST_BYTE;
      coarse_clamp_reg <= `LCC_RST_BYTE;
      green_clamp_reg  <= `LCC_RST_BYTE;
      placement_reg    <= `LCC_RST_BYTE;
      level_en_reg     <= `LCC_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `LCC_ADDR_LEVEL_COEF)
        level_coef_reg <= reg_wdata & `LCC_MASK_LEVEL_COEF;
      else if (reg_addr == `LCC_ADDR_FINE_CLAMP)
        fine_clamp_reg <= reg_wdata & `LCC_MASK_FINE_CLAMP;
      else if (reg_addr == `LCC_ADDR_POWER_DOWN)
        power_down_reg <= reg_wdata & `LCC_MASK_POWER_DOWN;
      else if (reg_addr == `LCC_ADDR_CONV_SETUP)
        conv_setup_reg <= reg_wdata & `LCC_MASK_CONV_SETUP;
      else if (reg_addr == `LCC_ADDR_COARSE_CLAMP)
        coarse_clamp_reg <= reg_wdata & `LCC_MASK_COARSE_CLAMP;
      else if (reg_addr == `LCC_ADDR_GREEN_CLAMP)
        green_clamp_reg <= reg_wdata & `LCC_MASK_GREEN_CLAMP;
      else if (reg_addr == `LCC_ADDR_PLACEMENT)
        placement_reg <= reg_wdata & `LCC_MASK_PLACEMENT;
      else if (reg_addr == `LCC_ADDR_LEVEL_EN)
        level_en_reg <= reg_wdata & `LCC_MASK_LEVEL_EN;
    end
  end

  // read mux, unmapped addresses read zero
  always @*
  begin
    if (reg_addr == `LCC_ADDR_LEVEL_COEF)
      reg_rdata = level_coef_reg;
    else if (reg_addr == `LCC_ADDR_FINE_CLAMP)
      reg_rdata = fine_clamp_reg;
    else if (reg_addr == `LCC_ADDR_POWER_DOWN)
      reg_rdata = power_down_reg;
    else if (reg_addr == `LCC_ADDR_CONV_SETUP)
      reg_rdata = conv_setup_reg;
    else if (reg_addr == `LCC_ADDR_COARSE_CLAMP)
      reg_rdata = coarse_clamp_reg;
    else if (reg_addr == `LCC_ADDR_GREEN_CLAMP)
      reg_rdata = green_clamp_reg;
    else if (reg_addr == `LCC_ADDR_PLACEMENT)
      reg_rdata = placement_reg;
    else if (reg_addr == `LCC_ADDR_LEVEL_EN)
      reg_rdata = level_en_reg;
    else
      reg_rdata = 8'h00;
  end

  // ****************************************************************
  // static control outputs
  // ****************************************************************
  assign fine_clamp_en        = fine_clamp_reg[2:0];
  assign fine_clamp_speed     = fine_clamp_reg[4:3];
  assign coarse_clamp_en      = coarse_clamp_reg[2:0];
  assign coarse_clamp_current = coarse_clamp_reg[7:6];
  assign green_sync_clamp_en  = green_clamp_reg[7];
  assign sync_on_green_pd     = power_down_reg[6];
  assign slicer_pd            = power_down_reg[5];
  assign reference_pd         = power_down_reg[4];
  assign current_control_pd   = power_down_reg[3];
  assign blue_converter_pd    = power_down_reg[2];
  assign green_converter_pd   = power_down_reg[1];
  assign red_converter_pd     = power_down_reg[0];
  assign converter_setup      = conv_setup_reg;
  assign level_loop_en        = level_en_reg[`LCC_LEVEL_EN_BIT];

  // ****************************************************************
  // level-control filter
  // ****************************************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_SUM   = 2'h2;
  localparam ST_APPLY = 2'h3;

  reg  [1:0]  state_reg;
  reg  [7:0]  delay_reg;
  reg  [9:0]  count_reg;
  reg  [19:0] sum_reg;
  reg  [2:0]  horizontal_sample_coeff_reg;
  reg  [3:0]  vertical_correction_coeff_reg;
  reg  [7:0]  place_reg;
  reg  [15:0] target_reg;
  wire [9:0]  count_last;
  wire [19:0] sum_scaled;
  wire [9:0]  average;
  wire signed [17:0] error;
  wire signed [17:0] step;

  // sample count is 8 shifted by the horizontal code
  assign count_last = (10'h001 << (horizontal_sample_coeff_reg +
                      `LCC_MIN_SAMPLES_LOG2)) - 10'h001;
  // divide by the count: scale the sum to 1024 samples, keep top bits
  assign sum_scaled = sum_reg << (3'h7 - horizontal_sample_coeff_reg);
  assign average    = sum_scaled[19:10];
  assign error      = $signed({2'b00, average, 6'h00}) -
                      $signed({2'b00, level_offset});
  assign step       = error >>> vertical_correction_coeff_reg;

  // line sequencer: latch, delay, accumulate, apply
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg     <= ST_IDLE;
      delay_reg     <= 8'h00;
      count_reg     <= 10'h000;
      sum_reg       <= 20'h00000;
      horizontal_sample_coeff_reg   <= 3'h0;
      vertical_correction_coeff_reg <= 4'h0;
      place_reg     <= 8'h00;
      target_reg    <= 16'h0000;
      level_offset  <= 16'h0000;
      offset_update <= 1'b0;
    end
    else
    begin
      offset_update <= 1'b0;
      if (hsync_start && level_loop_en)
      begin
        horizontal_sample_coeff_reg   <=
          level_coef_reg[`LCC_HORZ_COEF_MSB:`LCC_HORZ_COEF_LSB];
        vertical_correction_coeff_reg <=
          level_coef_reg[`LCC_VERT_COEF_MSB:`LCC_VERT_COEF_LSB];
        place_reg <= placement_reg;
        delay_reg <= 8'h00;
        count_reg <= 10'h000;
        sum_reg   <= 20'h00000;
        state_reg <= ST_DELAY;
      end
      else if (!level_loop_en)
        state_reg <= ST_IDLE;
      else
      begin
        case (state_reg)
          ST_DELAY:
          begin
            if (delay_reg == place_reg)
              state_reg <= ST_SUM;
            else
              delay_reg <= delay_reg + 8'h01;
          end
          ST_SUM:
          begin
            sum_reg <= sum_reg + {10'h000, blank_sample};
            if (count_reg == count_last)
              state_reg <= ST_APPLY;
            else
              count_reg <= count_reg + 10'h001;
          end
          ST_APPLY:
          begin
            level_offset  <= level_offset + step[15:0];
            offset_update <= 1'b1;
            state_reg     <= ST_IDLE;
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // lcc_level_control

// ---- lcc_level_control_properties.sv ----
`timescale 1ns/10ps
// ************************************
// port checker for the level control
// ************************************
module lcc_chk
(
  input wire       sys_clk,
  input wire       rst_b,
  input wire       reg_wr,
  input wire       offset_update,
  input wire       level_loop_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [2:0] fine_clamp_en,
  input wire [2:0] coarse_clamp_en,
  input wire [1:0] fine_clamp_speed,
  input wire [1:0] coarse_clamp_current,
  input wire       green_sync_clamp_en,
  input wire       sync_on_green_pd,
  input wire       slicer_pd,
  input wire       reference_pd,
  input wire       current_control_pd,
  input wire       blue_converter_pd,
  input wire       green_converter_pd,
  input wire       red_converter_pd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // address of a write in flight, ff when idle
  wire [7:0] wa = reg_wr ? reg_addr : 8'hff;
  a_fine_en_map: assert property (wa == 8'h2a |=>
    fine_clamp_en == $past(reg_wdata[2:0])) else $error("fine enables");
  a_fine_speed: assert property (wa == 8'h2a |=>
    fine_clamp_speed == $past(reg_wdata[4:3])) else $error("fine speed");
  a_block_pd: assert property (wa == 8'h2b |=>
    {sync_on_green_pd, slicer_pd, reference_pd, current_control_pd}
    == $past(reg_wdata[6:3])) else $error("block power");
  a_conv_pd: assert property (wa == 8'h2b |=>
    {blue_converter_pd, green_converter_pd, red_converter_pd}
    == $past(reg_wdata[2:0])) else $error("converter power");
  a_coarse_map: assert property (wa == 8'h2d |=>
    {coarse_clamp_current, coarse_clamp_en} == {$past(reg_wdata[7:6]),
    $past(reg_wdata[2:0])}) else $error("coarse clamp");
  a_green_clamp: assert property (wa == 8'h2e |=>
    green_sync_clamp_en == $past(reg_wdata[7])) else $error("green clamp");
  a_loop_gate: assert property ((!level_loop_en) [*3] |->
    !offset_update) else $error("update while disabled");
  a_rsvd_zero: assert property (reg_addr == 8'h2d |->
    reg_rdata[5:3] == 3'h0) else $error("reserved bits set");
  a_pulse_gap: assert property (offset_update |=>
    (!offset_update) [*8]) else $error("update too close");
  c_update: cover property (offset_update);
  c_power_wr: cover property (wa == 8'h2b);
  c_loop_on: cover property (level_loop_en && $rose(offset_update));
endmodule // lcc_chk

bind lcc_level_control lcc_chk chk_u (.*);

// ---- lcc_front_model.sv ----
`timescale 1ns/10ps
// ************************************
// front end stand-in: line timer
// ************************************
module lcc_front_model
#(
  parameter LINE = 1100
)
(
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire [9:0] level,
  output reg        hsync_start,
  output reg  [9:0] blank_sample
);
  integer cnt;
  // one start pulse per line, blank level follows the set level
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt <= 0;
      hsync_start <= 1'b0;
      blank_sample <= 10'h000;
    end
    else
    begin
      cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
      hsync_start <= (cnt == LINE - 1);
      blank_sample <= level;
    end
endmodule // lcc_front_model

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  reg         sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  reg  [9:0]  level = 10'h000;
  wire [7:0]  reg_rdata, converter_setup;
  wire [15:0] level_offset;
  wire [9:0]  blank_sample;
  wire        hsync_start, offset_update;
  integer     bad_count = 0, n_checks = 0, i, np;
  reg  [63:0] ads = 64'h28_2a_2b_2c_2d_2e_31_26;
  reg  [63:0] mks = 64'h7f_1f_7f_ff_c7_80_ff_80;
  always #25 sys_clk = ~sys_clk;
  lcc_front_model fe_u (.sys_clk(sys_clk), .rst_b(rst_b), .level(level),
    .hsync_start(hsync_start), .blank_sample(blank_sample));
  lcc_level_control dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .hsync_start(hsync_start),
    .blank_sample(blank_sample), .level_offset(level_offset),
    .offset_update(offset_update), .level_loop_en(), .fine_clamp_en(),
    .fine_clamp_speed(), .coarse_clamp_en(), .coarse_clamp_current(),
    .green_sync_clamp_en(), .sync_on_green_pd(), .slicer_pd(),
    .reference_pd(), .current_control_pd(), .blue_converter_pd(),
    .green_converter_pd(), .red_converter_pd(),
    .converter_setup(converter_setup));
  // compare and count
  task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // one register write, strobe held for one edge
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  // one register read, data settled a cycle after the address
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
  end
  endtask
  // time from line start to update, then the new offset; a placement
  // write lands one cycle after the line start and must not move this line's window
  task line(input [15:0] eo, input [15:0] ed);
    integer k;
  begin
    k = 0;
    @(posedge sys_clk iff hsync_start);
    reg_wr <= 1'b1;
    reg_addr <= 8'h31;
    reg_wdata <= 8'hff;
    while (offset_update !== 1'b1 && k < 1200)
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      k = k + 1;
    end
    chk("delay", ed, k[15:0]);
    chk("offset", eo, level_offset);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // watchdog well beyond the expected run
  initial
  begin
    #2000000;
    bad_count = bad_count + 1;
    end_sim;
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      rd(ads[i*8+:8], 8'h00);
      wr(ads[i*8+:8], 8'hff);
      rd(ads[i*8+:8], mks[i*8+:8]);
      wr(ads[i*8+:8], 8'h00);
    end
    wr(8'h27, 8'hff);
    rd(8'h27, 8'h00);
    wr(8'h2c, 8'h50);
    @(posedge sys_clk);
    chk("setup", 16'h0050, {8'h00, converter_setup});
    level <= 10'h100;
    wr(8'h31, 8'h18);
    wr(8'h26, 8'h80);
    line(16'h4000, 16'h0023);
    level <= 10'h080;
    wr(8'h28, 8'h0a);
    wr(8'h31, 8'h5a);
    line(16'h3000, 16'h007d);
    level <= 10'h200;
    wr(8'h28, 8'h77);
    wr(8'h31, 8'h00);
    line(16'h3001, 16'h0403);
    wr(8'h26, 8'h00);
    np = 0;
    repeat (1200)
    begin
      @(posedge sys_clk);
      if (offset_update === 1'b1)
        np = np + 1;
    end
    chk("pulses", 16'h0000, np[15:0]);
    end_sim;
  end
endmodule // tb
